/* File: mgmt_msg_cfg.svh */
`ifndef MGMT_MSG_CFG_SVH
`define MGMT_MSG_CFG_SVH

// fixed frame fields
`define MM_DA           48'h0180C2000002
`define MM_ETYPE        16'h8809
`define MM_SUBTYPE      8'h03
`define MM_FLAGS        16'h0000
`define MM_OAM_CODE     8'hFE
`define MM_TL_VER       8'h01
`define MM_TYPE_PDU     8'h00
`define MM_TYPE_ACK     8'h01
`define MM_PDU_VER      8'h01
`define MM_PDU_RSVD     8'h00

// response codes
`define MM_RC_OK        8'h00
`define MM_RC_VER       8'h01
`define MM_RC_SEQ       8'h02
`define MM_RC_EXCEED    8'h03

// byte positions inside a frame
`define MM_POS_SA_LO    9'h006
`define MM_POS_SA_HI    9'h00B
`define MM_POS_TLVER    9'h015
`define MM_POS_TYPE     9'h016
`define MM_POS_SEQ_HI   9'h017
`define MM_POS_SEQ_LO   9'h018
`define MM_POS_TOT_HI   9'h019
`define MM_POS_TOT_LO   9'h01A
`define MM_POS_LEN      9'h01B
`define MM_POS_PAY      9'h01C
`define MM_POS_ETYPE    9'h00C
`define MM_PDU_HDR_LEN  16'h0006

// retry and timing
`define MM_MAX_ATTEMPTS 3'h4
`define MM_CLK_NS       8
`define MM_ACK_TMO_NS   100000
`define MM_ACK_TMO_CYC  (`MM_ACK_TMO_NS / `MM_CLK_NS)

`endif

/* File: mgmt_msg_pkg.sv */
package mgmt_msg_pkg;

    typedef struct packed {
        logic [7:0]  ver;
        logic [7:0]  typ;
        logic [15:0] seq;
        logic [15:0] total;
        logic [7:0]  len;
    } tl_hdr_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } rx_word_t;

    typedef enum logic [1:0] {
        M_IDLE,
        M_SEND,
        M_WAIT
    } msg_state_t;

endpackage : mgmt_msg_pkg

/* File: mgmt_msg_oam_transport.sv */
`timescale 1ns/1ps
`include "mgmt_msg_cfg.svh"
module mgmt_msg_oam_transport #(
    parameter int          FRAG    = 32,
    parameter int          MSG_MAX = 128,
    parameter int          TMO_CYC = `MM_ACK_TMO_CYC,
    parameter logic [47:0] SRC_MAC = 48'h020000000001,
    parameter logic [23:0] OUI     = 24'h00A0B0 // value arbitrary
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // message load and send
    input  wire logic                       msg_wr_en,
    input  wire logic [$clog2(MSG_MAX)-1:0] msg_wr_addr,
    input  wire logic [7:0]                 msg_wr_data,
    input  wire logic                       msg_send,
    input  wire logic [15:0]                msg_id,
    input  wire logic [15:0]                msg_opcode,
    input  wire logic [15:0]                msg_len,
    output logic                            msg_idle,
    output logic                            msg_sent,
    output logic                            chan_lost,
    // link byte stream out
    output logic                            tx_valid,
    output logic [7:0]                      tx_data,
    output logic                            tx_last,
    input  wire logic                       tx_ready,
    // link byte stream in
    input  wire logic                       rx_valid,
    input  wire logic [7:0]                 rx_data,
    input  wire logic                       rx_last,
    output logic                            rx_ready,
    // received message data
    output logic                            out_valid,
    output logic [7:0]                      out_data,
    output logic                            out_last,
    input  wire logic                       out_ready,
    output logic                            rx_msg_done,
    output logic [15:0]                     rx_msg_id,
    output logic [15:0]                     rx_msg_opcode
);
    localparam int AW = $clog2(MSG_MAX);

    function automatic logic [7:0] hdr_byte(input logic [8:0] i,
            input mgmt_msg_pkg::tl_hdr_t h, input logic [47:0] sa);
        logic [223:0] hv;
        logic [4:0]   k;
        hv = {`MM_DA, sa, `MM_ETYPE, `MM_SUBTYPE, `MM_FLAGS, `MM_OAM_CODE,
              OUI, h};
        k = 5'(9'd27 - i);
        hdr_byte = hv[{k, 3'b000} +: 8];
    endfunction : hdr_byte

    // ---------------- message store and send state
    logic [7:0]               buf_r [MSG_MAX];
    mgmt_msg_pkg::msg_state_t mst_r;
    logic [15:0]              id_r, op_r, bytes_r, total_r, seq_r, base_r;
    logic [2:0]               att_r;
    logic [31:0]              tmr_r;
    logic                     ack_evt_r;
    logic [7:0]               ack_rc_r;
    logic [15:0]              ack_seq_r;
    logic                     tmo, ack_good, ack_bad, pdu_go;

    always_ff @(posedge clk) begin
        if (msg_wr_en && mst_r == mgmt_msg_pkg::M_IDLE) begin
            buf_r[msg_wr_addr] <= msg_wr_data;
        end
    end

    assign tmo      = mst_r == mgmt_msg_pkg::M_WAIT && tmr_r >= 32'(TMO_CYC);
    assign ack_good = mst_r == mgmt_msg_pkg::M_WAIT && ack_evt_r
                      && ack_seq_r == seq_r && ack_rc_r == `MM_RC_OK;
    assign ack_bad  = mst_r == mgmt_msg_pkg::M_WAIT && ack_evt_r
                      && ack_seq_r == seq_r && ack_rc_r != `MM_RC_OK;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mst_r     <= mgmt_msg_pkg::M_IDLE;
            id_r      <= 16'h0000;
            op_r      <= 16'h0000;
            bytes_r   <= 16'h0000;
            total_r   <= 16'h0000;
            seq_r     <= 16'h0000;
            base_r    <= 16'h0000;
            att_r     <= 3'h0;
            tmr_r     <= 32'h0;
            msg_sent  <= 1'b0;
            chan_lost <= 1'b0;
        end else begin
            msg_sent  <= 1'b0;
            chan_lost <= 1'b0;
            tmr_r     <= tmr_r + 32'h1;
            case (mst_r)
                mgmt_msg_pkg::M_IDLE: begin
                    if (msg_send) begin
                        id_r    <= msg_id;
                        op_r    <= msg_opcode;
                        bytes_r <= msg_len + `MM_PDU_HDR_LEN;
                        total_r <= 16'((32'(msg_len) + 32'(`MM_PDU_HDR_LEN)
                                       + 32'(FRAG) - 1) / 32'(FRAG));
                        seq_r   <= 16'h0000;
                        base_r  <= 16'h0000;
                        att_r   <= 3'h0;
                        mst_r   <= mgmt_msg_pkg::M_SEND;
                    end
                end
                mgmt_msg_pkg::M_SEND: begin
                    if (pdu_go) begin
                        att_r <= att_r + 3'h1;
                        tmr_r <= 32'h0;
                        mst_r <= mgmt_msg_pkg::M_WAIT;
                    end
                end
                mgmt_msg_pkg::M_WAIT: begin
                    if (ack_good) begin
                        att_r <= 3'h0;
                        if (seq_r + 16'h1 == total_r) begin
                            msg_sent <= 1'b1;
                            mst_r    <= mgmt_msg_pkg::M_IDLE;
                        end else begin
                            seq_r  <= seq_r + 16'h1;
                            base_r <= base_r + 16'(FRAG);
                            mst_r  <= mgmt_msg_pkg::M_SEND;
                        end
                    end else if (tmo || ack_bad) begin
                        if (att_r == `MM_MAX_ATTEMPTS) begin
                            chan_lost <= 1'b1;
                            mst_r     <= mgmt_msg_pkg::M_IDLE;
                        end else begin
                            mst_r <= mgmt_msg_pkg::M_SEND;
                        end
                    end
                end
                default: mst_r <= mgmt_msg_pkg::M_IDLE;
            endcase
        end
    end

    assign msg_idle = mst_r == mgmt_msg_pkg::M_IDLE;

    // ---------------- frame emitter, acknowledgements first
    mgmt_msg_pkg::tl_hdr_t cur_h_r, ackq_h_r;
    logic       busy_r, is_ack_r, ackq_r;
    logic [7:0] cur_rc_r, ackq_rc_r;
    logic [8:0] tx_idx_r, end_r;
    logic [15:0] remain, fr_len, off;
    logic       ld, ack_go;
    logic [7:0] pay;

    assign remain = bytes_r - base_r;
    assign fr_len = remain > 16'(FRAG) ? 16'(FRAG) : remain;
    assign ack_go = !busy_r && ackq_r;
    assign pdu_go = !busy_r && !ackq_r && mst_r == mgmt_msg_pkg::M_SEND;
    assign ld     = busy_r && (!tx_valid || tx_ready);
    assign off    = base_r + 16'(tx_idx_r - `MM_POS_PAY);

    always_comb begin
        pay = 8'h00;
        case (off[2:0])
            3'h0: pay = `MM_PDU_VER;
            3'h1: pay = `MM_PDU_RSVD;
            3'h2: pay = id_r[15:8];
            3'h3: pay = id_r[7:0];
            3'h4: pay = op_r[15:8];
            3'h5: pay = op_r[7:0];
            default: pay = 8'h00;
        endcase
        if (off >= `MM_PDU_HDR_LEN) begin
            pay = buf_r[AW'(off - `MM_PDU_HDR_LEN)];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_r   <= 1'b0;
            is_ack_r <= 1'b0;
            cur_h_r  <= '0;
            cur_rc_r <= 8'h00;
            tx_idx_r <= 9'h000;
            end_r    <= 9'h000;
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_last  <= 1'b0;
        end else begin
            if (tx_valid && tx_ready && tx_last) begin
                tx_valid <= 1'b0;
            end
            if (ack_go) begin
                busy_r   <= 1'b1;
                is_ack_r <= 1'b1;
                cur_h_r  <= ackq_h_r;
                cur_rc_r <= ackq_rc_r;
                tx_idx_r <= 9'h000;
                end_r    <= `MM_POS_PAY;
            end else if (pdu_go) begin
                busy_r   <= 1'b1;
                is_ack_r <= 1'b0;
                cur_h_r  <= '{ver: `MM_TL_VER, typ: `MM_TYPE_PDU, seq: seq_r,
                              total: total_r, len: fr_len[7:0]};
                tx_idx_r <= 9'h000;
                end_r    <= 9'(`MM_POS_PAY + fr_len[8:0] - 9'h1);
            end else if (ld) begin
                tx_valid <= 1'b1;
                tx_last  <= tx_idx_r == end_r;
                tx_idx_r <= tx_idx_r + 9'h1;
                if (tx_idx_r < `MM_POS_PAY) begin
                    tx_data <= hdr_byte(tx_idx_r, cur_h_r, SRC_MAC);
                end else begin
                    tx_data <= is_ack_r ? cur_rc_r : pay;
                end
                if (tx_idx_r == end_r) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    // ---------------- receive parser
    mgmt_msg_pkg::tl_hdr_t rh_r;
    logic [8:0]  rx_idx_r;
    logic        bad_r, keep_r, last_ok_r;
    logic [15:0] last_seq_r, exp_seq_r, got_r, roff_r;
    logic [7:0]  rc_r, exp_b;
    logic        acc, deliver, fifo_in_rdy, dup;
    logic [7:0]  rc_nxt;

    assign acc     = rx_valid && rx_ready;
    assign deliver = keep_r && rx_idx_r >= `MM_POS_PAY
                     && (rh_r.seq != 16'h0 || roff_r >= `MM_PDU_HDR_LEN);
    assign rx_ready = !(rx_idx_r == 9'h000 && ackq_r)
                      && (!deliver || fifo_in_rdy);
    assign exp_b   = hdr_byte(rx_idx_r, rh_r, 48'h0);
    assign dup     = last_ok_r && rh_r.seq == last_seq_r;

    always_comb begin
        rc_nxt = `MM_RC_OK;
        if (rh_r.ver != `MM_TL_VER) begin
            rc_nxt = `MM_RC_VER;
        end else if (dup) begin
            rc_nxt = `MM_RC_OK;
        end else if (rh_r.seq >= rh_r.total) begin
            rc_nxt = `MM_RC_EXCEED;
        end else if (rh_r.seq != exp_seq_r && rh_r.seq != 16'h0) begin
            rc_nxt = `MM_RC_SEQ;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_idx_r      <= 9'h000;
            rh_r          <= '0;
            bad_r         <= 1'b0;
            keep_r        <= 1'b0;
            rc_r          <= 8'h00;
            roff_r        <= 16'h0000;
            last_ok_r     <= 1'b0;
            last_seq_r    <= 16'h0000;
            exp_seq_r     <= 16'h0000;
            got_r         <= 16'h0000;
            ackq_r        <= 1'b0;
            ackq_h_r      <= '0;
            ackq_rc_r     <= 8'h00;
            ack_evt_r     <= 1'b0;
            ack_rc_r      <= 8'h00;
            ack_seq_r     <= 16'h0000;
            rx_msg_done   <= 1'b0;
            rx_msg_id     <= 16'h0000;
            rx_msg_opcode <= 16'h0000;
        end else begin
            ack_evt_r   <= 1'b0;
            rx_msg_done <= 1'b0;
            if (ack_go) begin
                ackq_r <= 1'b0;
            end
            if (acc) begin
                rx_idx_r <= rx_last ? 9'h000 : rx_idx_r + 9'h1;
                if (rx_idx_r < `MM_POS_TLVER && rx_data != exp_b
                    && !(rx_idx_r >= `MM_POS_SA_LO
                         && rx_idx_r <= `MM_POS_SA_HI)) begin
                    bad_r <= 1'b1;
                end
                case (rx_idx_r)
                    `MM_POS_TLVER:  rh_r.ver         <= rx_data;
                    `MM_POS_TYPE:   rh_r.typ         <= rx_data;
                    `MM_POS_SEQ_HI: rh_r.seq[15:8]   <= rx_data;
                    `MM_POS_SEQ_LO: rh_r.seq[7:0]    <= rx_data;
                    `MM_POS_TOT_HI: rh_r.total[15:8] <= rx_data;
                    `MM_POS_TOT_LO: rh_r.total[7:0]  <= rx_data;
                    `MM_POS_LEN: begin
                        rh_r.len <= rx_data;
                        rc_r     <= rc_nxt;
                        keep_r   <= !bad_r && rh_r.typ == `MM_TYPE_PDU
                                    && rc_nxt == `MM_RC_OK && !dup;
                        roff_r   <= 16'h0000;
                    end
                    default: roff_r <= roff_r + 16'h1;
                endcase
                if (keep_r && rh_r.seq == 16'h0
                    && rx_idx_r >= `MM_POS_PAY
                    && roff_r < `MM_PDU_HDR_LEN) begin
                    case (roff_r[2:0])
                        3'h2: rx_msg_id[15:8]     <= rx_data;
                        3'h3: rx_msg_id[7:0]      <= rx_data;
                        3'h4: rx_msg_opcode[15:8] <= rx_data;
                        3'h5: rx_msg_opcode[7:0]  <= rx_data;
                        default: ;
                    endcase
                end
                if (rx_last) begin
                    bad_r  <= 1'b0;
                    keep_r <= 1'b0;
                    if (!bad_r && rh_r.typ == `MM_TYPE_ACK) begin
                        ack_evt_r <= 1'b1;
                        ack_seq_r <= rh_r.seq;
                        ack_rc_r  <= rx_data;
                    end
                    if (!bad_r && rh_r.typ == `MM_TYPE_PDU) begin
                        ackq_r    <= 1'b1;
                        ackq_h_r  <= '{ver: rh_r.ver, typ: `MM_TYPE_ACK,
                                       seq: rh_r.seq, total: rh_r.total,
                                       len: rh_r.len};
                        ackq_rc_r <= rc_r;
                        last_ok_r <= rc_r == `MM_RC_OK;
                        last_seq_r <= rh_r.seq;
                    end
                    if (keep_r) begin
                        exp_seq_r <= rh_r.seq + 16'h1;
                        got_r <= rh_r.seq == 16'h0 ? 16'h1 : got_r + 16'h1;
                        if ((rh_r.seq == 16'h0 ? 16'h1 : got_r + 16'h1)
                            == rh_r.total) begin
                            rx_msg_done <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // ---------------- two-entry buffer for received data
    mgmt_msg_pkg::rx_word_t fifo_r [2];
    logic [1:0] wp_r, rp_r;
    logic       f_full, f_empty;

    assign f_full      = wp_r == {~rp_r[1], rp_r[0]};
    assign f_empty     = wp_r == rp_r;
    assign fifo_in_rdy = !f_full;
    assign out_valid   = !f_empty;
    assign out_data    = fifo_r[rp_r[0]].data;
    assign out_last    = fifo_r[rp_r[0]].last;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= 2'h0;
            rp_r <= 2'h0;
        end else begin
            if (acc && deliver) begin
                wp_r <= wp_r + 2'h1;
            end
            if (out_valid && out_ready) begin
                rp_r <= rp_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (acc && deliver) begin
            fifo_r[wp_r[0]] <= '{data: rx_data, last: rx_last};
        end
    end

    // ---------------- checks
    a_retry_limit_hit: assert property (@(posedge clk) disable iff (rst)
        chan_lost |-> $past(att_r) == 3'h4 && msg_idle)
        else $error("channel loss without four attempts");
    a_one_outstanding: assert property (@(posedge clk) disable iff (rst)
        pdu_go |-> mst_r == mgmt_msg_pkg::M_SEND ##1 !pdu_go)
        else $error("second fragment started while waiting");
    a_seq_ascend: assert property (@(posedge clk) disable iff (rst)
        $changed(seq_r) |-> seq_r == $past(seq_r) + 16'h1 || seq_r == 16'h0)
        else $error("sequence number skipped");
    a_retx_on_fail: assert property (@(posedge clk) disable iff (rst)
        (tmo || ack_bad) && att_r != 3'h4 && !ack_good
        |=> mst_r == mgmt_msg_pkg::M_SEND)
        else $error("failed fragment not retransmitted");
    a_dup_ack_ok: assert property (@(posedge clk) disable iff (rst)
        acc && rx_idx_r == `MM_POS_LEN && dup && rh_r.ver == `MM_TL_VER
        |=> rc_r == `MM_RC_OK && !keep_r)
        else $error("duplicate not acknowledged valid");
    a_ver_reject_code: assert property (@(posedge clk) disable iff (rst)
        acc && rx_idx_r == `MM_POS_LEN && rh_r.ver != `MM_TL_VER
        |=> rc_r == `MM_RC_VER)
        else $error("bad version not rejected");
    a_ack_header_copy: assert property (@(posedge clk) disable iff (rst)
        ack_go |=> cur_h_r.typ == `MM_TYPE_ACK && end_r == `MM_POS_PAY)
        else $error("acknowledgement frame malformed");
    a_ethertype_byte: assert property (@(posedge clk) disable iff (rst)
        ld && tx_idx_r == `MM_POS_ETYPE |=> tx_data == 8'h88)
        else $error("ethertype high byte wrong");
    a_msg_complete: assert property (@(posedge clk) disable iff (rst)
        rx_msg_done |-> $past(got_r) + 16'h1 == rh_r.total
                        || rh_r.total == 16'h1)
        else $error("message done with fragments missing");

    c_chan_lost: cover property (@(posedge clk) disable iff (rst) chan_lost);
    c_msg_sent: cover property (@(posedge clk) disable iff (rst) msg_sent);
    c_rx_done: cover property (@(posedge clk) disable iff (rst) rx_msg_done);
    c_fifo_full: cover property (@(posedge clk) disable iff (rst)
        f_full && !out_ready);

endmodule : mgmt_msg_oam_transport

/* File: peer_model.sv */
`timescale 1ns/1ps
module peer_model #(
    parameter logic [23:0] OUI = 24'h00A0B0 // value arbitrary
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // frames from the controller
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready,
    // frames to the controller
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_last,
    input  wire logic       rx_ready,
    // reply control
    input  wire logic       ack_en,
    input  wire logic [7:0] ack_code
);
    logic [7:0]            got_q[$];
    logic [8:0]            out_q[$];
    mgmt_msg_pkg::tl_hdr_t hdr_q[$];
    logic [7:0]            code_q[$];
    mgmt_msg_pkg::tl_hdr_t h;
    logic [63:0]           w;
    logic [63:0]           word_q[$];

    task automatic push(input mgmt_msg_pkg::tl_hdr_t t,
                        input logic [7:0] p[$]);
        logic [7:0] b[$];
        b = {8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h02, 8'h02, 8'h00,
             8'h00, 8'h00, 8'h00, 8'h03, 8'h88, 8'h09, 8'h03};
        b = {b, 8'h00, 8'h00, 8'hFE, OUI[23:16], OUI[15:8],
             OUI[7:0]};
        for (int i = 6; i >= 0; i--)
            b.push_back(t[i*8 +: 8]);
        b = {b, p};
        foreach (b[i])
            out_q.push_back({i == b.size() - 1, b[i]});
    endtask : push

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_data  <= 8'h00;
            rx_last  <= 1'b0;
            out_q.delete();
            got_q.delete();
        end else begin
            // stall every other cycle
            tx_ready <= ~tx_ready;
            if (rx_valid && rx_ready)
                void'(out_q.pop_front());
            if (tx_valid && tx_ready) begin
                got_q.push_back(tx_data);
                if (tx_last) begin
                    for (int i = 0; i < 7; i++)
                        h[55-8*i -: 8] = got_q[21+i];
                    hdr_q.push_back(h);
                    code_q.push_back(tx_data);
                    // ethertype and first six payload bytes of each frame
                    w = {got_q[12], got_q[13], 48'h0};
                    foreach (got_q[i])
                        if (i >= 28 && i < 34)
                            w[8*(33-i) +: 8] = got_q[i];
                    word_q.push_back(w);
                    if (h.typ == 8'h00 && ack_en) begin
                        h.typ = 8'h01;
                        push(h, {ack_code});
                    end
                    got_q.delete();
                end
            end
            rx_valid <= out_q.size() != 0;
            rx_data  <= out_q.size() != 0 ? out_q[0][7:0] : ~rx_data;
            rx_last  <= out_q.size() != 0 && out_q[0][8];
        end
    end
endmodule : peer_model

/* File: tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
 mismatches++; $display("BAD %s expected %0h seen %0h", n, e, s); end end
module tb;
    typedef struct {
        logic [7:0]  ver;
        logic [15:0] seq;
        logic [15:0] tot;
        logic [7:0]  code;
    } row_t;
    logic clk = 1'b0, rst, msg_wr_en, msg_send, msg_idle, msg_sent, chan_lost;
    logic [6:0] msg_wr_addr;
    logic [7:0] msg_wr_data, tx_data, rx_data, out_data, ack_code, c, first;
    logic [15:0] msg_id, msg_opcode, msg_len, rx_msg_id, rx_msg_opcode;
    logic tx_valid, tx_last, tx_ready, rx_valid, rx_last, rx_ready, ack_en;
    logic out_valid, out_last, out_ready = 1'b0, rx_msg_done;
    mgmt_msg_pkg::tl_hdr_t h, g;
    logic [63:0] fw;
    logic [47:0] heads [2] = '{48'h0100BEEF0A0B, 48'h1A1B1C1D1E1F};
    logic [7:0] pay[$] = '{8'h01, 8'h00, 8'h12, 8'h34, 8'h00, 8'h05,
                           8'hA0, 8'hA1};
    int mismatches = 0, check_count = 0, cyc = 0;
    int n_sent = 0, n_lost = 0, n_done = 0, n_out = 0, n_olast = 0;
    row_t rows [6] = '{'{8'h01, 16'h0000, 16'h0002, 8'h00},
        '{8'h01, 16'h0000, 16'h0002, 8'h00}, '{8'h02, 16'h0001, 16'h0002,
        8'h01}, '{8'h01, 16'h0002, 16'h0002, 8'h03}, '{8'h01, 16'h0004,
        16'h0009, 8'h02}, '{8'h01, 16'h0001, 16'h0002, 8'h00}};

    mgmt_msg_oam_transport #(.TMO_CYC(400)) i_mgmt_msg_oam_transport (.*);
    peer_model i_peer_model (.*);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(negedge clk)
        out_ready <= ~out_ready;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_sent <= n_sent + msg_sent;
        n_lost <= n_lost + chan_lost;
        n_done <= n_done + rx_msg_done;
        if (out_valid && out_ready && n_out == 0)
            first <= out_data;
        n_out <= n_out + (out_valid && out_ready);
        n_olast <= n_olast + (out_valid && out_ready && out_last);
        if (cyc == 30000) begin
            mismatches++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic get_frame();
        for (int n = 0; n < 3000 && i_peer_model.hdr_q.size() == 0; n++)
            @(negedge clk);
        `CHK("frame seen", 1'b1, i_peer_model.hdr_q.size() != 0)
        g = i_peer_model.hdr_q.pop_front();
        c = i_peer_model.code_q.pop_front();
        fw = i_peer_model.word_q.pop_front();
    endtask : get_frame

    task automatic send(input logic [15:0] len);
        for (int n = 0; n < len; n++) begin
            {msg_wr_en, msg_wr_addr, msg_wr_data} = {1'b1, 7'(n), 8'(n)};
            @(negedge clk);
        end
        {msg_wr_en, msg_send, msg_id, msg_opcode, msg_len} =
            {2'b01, 16'hBEEF, 16'h0A0B, len};
        @(negedge clk);
        msg_send = 1'b0;
    endtask : send

    task automatic wait_idle();
        for (int n = 0; n < 6000 && !msg_idle; n++)
            @(negedge clk);
        // let the end pulse be counted
        @(negedge clk);
    endtask : wait_idle

    initial begin
        {rst, msg_wr_en, msg_send, ack_en} = 4'b1001;
        {msg_wr_addr, msg_wr_data, msg_id, msg_opcode, msg_len} = '0;
        ack_code = 8'h00;
        repeat (16) @(negedge clk);
        `CHK("idle in reset", 1'b1, msg_idle)
        `CHK("rx_ready in reset", 1'b1, rx_ready)
        `CHK("tx_valid in reset", 1'b0, tx_valid)
        rst = 1'b0;
        foreach (rows[i]) begin
            h = '{rows[i].ver, 8'h00, rows[i].seq, rows[i].tot, 8'h08};
            i_peer_model.push(h, pay);
            get_frame();
            `CHK("ack type", 8'h01, g.typ)
            `CHK("ack seq", h.seq, g.seq)
            `CHK("ack total", h.total, g.total)
            `CHK("ack ver", h.ver, g.ver)
            `CHK("ack len", h.len, g.len)
            `CHK("ack code", rows[i].code, c)
        end
        repeat (60) @(negedge clk);
        `CHK("msg done", 1, n_done)
        `CHK("msg id", 16'h1234, rx_msg_id)
        `CHK("opcode", 16'h0005, rx_msg_opcode)
        `CHK("first data", 8'hA0, first)
        `CHK("data count", 10, n_out)
        `CHK("last count", 2, n_olast)
        send(16'h0028);
        for (int k = 0; k < 2; k++) begin
            get_frame();
            `CHK("pdu type", 8'h00, g.typ)
            `CHK("pdu version", 8'h01, g.ver)
            `CHK("pdu seq", 16'(k), g.seq)
            `CHK("pdu total", 16'h0002, g.total)
            `CHK("pdu len", k ? 8'h0E : 8'h20, g.len)
            `CHK("pdu etype", 16'h8809, fw[63:48])
            `CHK("pdu w0", heads[k][47:32], fw[47:32])
            `CHK("pdu w1", heads[k][31:16], fw[31:16])
            `CHK("pdu w2", heads[k][15:0], fw[15:0])
        end
        wait_idle();
        `CHK("sent", 1, n_sent)
        for (int m = 0; m < 2; m++) begin
            {ack_en, ack_code} = {m == 0, 8'h02};
            send(16'h000A);
            for (int k = 0; k < 4; k++) begin
                get_frame();
                `CHK("retry seq", 16'h0000, g.seq)
            end
            wait_idle();
            `CHK("lost", m + 1, n_lost)
            `CHK("no fifth", 0, i_peer_model.hdr_q.size())
        end
        results();
    end
endmodule : tb
